// ==== include/pssa_pkg.sv ====
// Package with constants and types shared by both ends of the pipelined SRAM link.
`default_nettype none
package pssa_pkg;
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 36;
    localparam int LANES    = 4;
    localparam int LANE_W   = 9;
    localparam int DEPTH    = 256;
    localparam int WR_LAT   = 2;
    localparam logic [1:0] BURST_RST = 2'h0;
    localparam logic       SEL_RST   = 1'h0;

    typedef enum logic [3:0] {
        PSSA_IDLE_ST  = 4'h1,
        PSSA_ISSUE_ST = 4'h2,
        PSSA_WAIT_ST  = 4'h4,
        PSSA_DONE_ST  = 4'h8
    } pssa_host_state_type;
endpackage : pssa_pkg
`default_nettype wire

// ==== include/pssa_if.sv ====
// Interface carrying the synchronous SRAM pins between controller and memory.
`timescale 1ns/10ps
`default_nettype none
interface pssa_if;
    import pssa_pkg::*;
    logic                clock_qualifier_n;
    logic                chip_select_1_n;
    logic                chip_select_2;
    logic                chip_select_3_n;
    logic                step_or_load_n;
    logic                write_sel_n;
    logic [LANES-1:0]    byte_lane_select_n;
    logic [ADDR_W-1:0]   addr;
    logic                out_enable_n;
    logic                burst_order;
    logic [DATA_W-1:0]   dq_host_o;
    logic                dq_host_oe;
    logic [DATA_W-1:0]   dq_mem_o;
    logic                dq_mem_oe;
    logic [DATA_W-1:0]   dq;
    logic                tck;
    logic                tms;
    logic                tdi;
    logic                tdo;
    logic                tdo_oe;

    // Resolved bus level; contention reads as the host value.
    assign dq = dq_host_oe ? dq_host_o : (dq_mem_oe ? dq_mem_o : '0);

    modport mem (
        input  clock_qualifier_n, chip_select_1_n, chip_select_2, chip_select_3_n,
        input  step_or_load_n, write_sel_n, byte_lane_select_n, addr, out_enable_n,
        input  burst_order, dq, tck, tms, tdi,
        output dq_mem_o, dq_mem_oe, tdo, tdo_oe
    );
    modport host (
        output clock_qualifier_n, chip_select_1_n, chip_select_2, chip_select_3_n,
        output step_or_load_n, write_sel_n, byte_lane_select_n, addr, out_enable_n,
        output burst_order, dq_host_o, dq_host_oe, tck, tms, tdi,
        input  dq, tdo, tdo_oe
    );
endinterface : pssa_if
`default_nettype wire

// ==== hdl/pssa_mem.sv ====
// Memory end: pipelined synchronous burst SRAM with a small test port.
//
// Functional notes
// - Qualifier high freezes all internal state except the test port.
// - Register every synchronous input on rising edge.
// - Read data leaves through an output register.
// - Selects asserted (select 2 high), qualifier and load low start access.
// - Write select at that edge picks read/write.
// - Byte lane selects choose written bytes.
// - Host starts read with write select high.
// - Read data drives one edge after issue.
// - Output enable and control logic gate drivers.
// - Host holds output enable low for reads.
// - Next operation may issue on read's second clock.
// - Deselect floats outputs after next edge.
// - Host loads fresh address after deselect.
// - Writes are self-timed internally.
// - Test data out changes on falling test clock.
// - Test data in sampled on rising test clock.
// - Mode select sampled on rising edge, drives states.
// - Write data follows address two qualified clocks later.
// - Step high advances burst counter regardless.
// - Burst order high interleaved, low linear.
// - Outputs float first clock after deselect.
`timescale 1ns/10ps
`default_nettype none
module pssa_mem
    import pssa_pkg::*;
(
    input  wire logic i_ref_clk,
    input  wire logic i_srst,
    input  wire logic i_clk_en,
    pssa_if.mem       bus,
    output logic      o_busy
);
    // ----------------------------------------------------------------
    // Pipeline state
    // ----------------------------------------------------------------
    wire logic [DATA_W-1:0] rd_word;
    logic [ADDR_W-1:0] base_q, base_d;
    logic [1:0]        cnt_q, cnt_d;
    logic              act_q, act_d;
    logic              wr_q, wr_d;
    logic              rd1_q, rd1_d;
    logic              wr1_q, wr1_d;
    logic [ADDR_W-1:0] a1_q, a1_d;
    logic              wr2_q, wr2_d;
    logic [ADDR_W-1:0] a2_q, a2_d;
    logic              desel_q, desel_d;
    logic              fresh_q, fresh_d;
    logic [DATA_W-1:0] out_q, out_d;
    logic              drv_q, drv_d;
    logic              busy_q, busy_d;
    logic              qual;
    logic              selected;
    logic              load;

    function automatic logic [1:0] burst_step(input logic [1:0] start, input logic [1:0] n,
                                              input logic interleave);
        burst_step = interleave ? (start ^ n) : 2'(start + n);
    endfunction

    assign qual     = i_clk_en && !bus.clock_qualifier_n;
    assign selected = !bus.chip_select_1_n && bus.chip_select_2 && !bus.chip_select_3_n;
    assign load     = qual && !bus.step_or_load_n;

    always_comb begin
        logic [1:0] nxt;
        nxt      = 2'(cnt_q + 2'h1);
        base_d   = base_q;
        cnt_d    = cnt_q;
        act_d    = act_q;
        wr_d     = wr_q;
        rd1_d    = 1'b0;
        wr1_d    = 1'b0;
        a1_d     = a1_q;
        if (load) begin
            act_d = selected;
            if (selected) begin
                base_d = bus.addr;
                cnt_d  = BURST_RST;
                wr_d   = !bus.write_sel_n;
                rd1_d  = bus.write_sel_n;
                wr1_d  = !bus.write_sel_n;
                a1_d   = bus.addr;
            end
        end else if (qual) begin
            cnt_d = nxt;
            rd1_d = act_q && !wr_q;
            wr1_d = act_q && wr_q;
            a1_d  = {base_q[ADDR_W-1:2], burst_step(base_q[1:0], nxt, bus.burst_order)};
        end
        if (!qual) begin
            rd1_d = rd1_q;
            wr1_d = wr1_q;
        end
    end

    always_comb begin
        wr2_d   = wr2_q;
        a2_d    = a2_q;
        desel_d = desel_q;
        fresh_d = fresh_q;
        out_d   = out_q;
        drv_d   = drv_q;
        busy_d  = busy_q;
        if (qual) begin
            wr2_d   = wr1_q;
            a2_d    = a1_q;
            out_d   = rd_word;
            // A read issued on the previous read's second clock drives without a gap.
            drv_d   = rd1_q;
            fresh_d = desel_q && (rd1_d || wr1_d);
            desel_d = !(rd1_d || wr1_d);
            busy_d  = rd1_q || wr1_q || wr2_q;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            base_q  <= '0;
            cnt_q   <= BURST_RST;
            act_q   <= SEL_RST;
            wr_q    <= 1'b0;
            rd1_q   <= 1'b0;
            wr1_q   <= 1'b0;
            a1_q    <= '0;
            wr2_q   <= 1'b0;
            a2_q    <= '0;
            desel_q <= 1'b1;
            fresh_q <= 1'b0;
            out_q   <= '0;
            drv_q   <= 1'b0;
            busy_q  <= 1'b0;
        end else if (i_clk_en) begin
            base_q  <= base_d;
            cnt_q   <= cnt_d;
            act_q   <= act_d;
            wr_q    <= wr_d;
            rd1_q   <= rd1_d;
            wr1_q   <= wr1_d;
            a1_q    <= a1_d;
            wr2_q   <= wr2_d;
            a2_q    <= a2_d;
            desel_q <= desel_d;
            fresh_q <= fresh_d;
            out_q   <= out_d;
            drv_q   <= drv_d;
            busy_q  <= busy_d;
        end
    end

    // Byte writes complete in one qualified edge, no external pulse timing.
    generate
        for (genvar g = 0; g < LANES; g++) begin : g_lane
            logic [LANE_W-1:0] lane_q [DEPTH];
            always_ff @(posedge i_ref_clk) begin
                if (qual && wr2_q && !bus.byte_lane_select_n[g]) begin
                    lane_q[a2_q] <= bus.dq[g*LANE_W +: LANE_W];
                end
            end
            assign rd_word[g*LANE_W +: LANE_W] = lane_q[a1_q];
        end
    endgenerate

    assign bus.dq_mem_o  = out_q;
    assign bus.dq_mem_oe = drv_q && !bus.out_enable_n && !wr2_q && !fresh_q;
    assign o_busy        = busy_q;

    // ----------------------------------------------------------------
    // Test port: bypass register between data in and data out
    // ----------------------------------------------------------------
    // The test clock is sampled like any other pin, so its edges are seen one
    // system clock late and only while the clock enable is high.
    // Five mode-select rises in a row park the port with its output off.
    logic       tck_q, tck_d;
    logic       tdi_q, tdi_d;
    logic       tdo_q, tdo_d;
    logic       tdo_oe_q, tdo_oe_d;
    logic [2:0] tms_ones_q, tms_ones_d;

    always_comb begin
        tck_d      = bus.tck;
        tdi_d      = tdi_q;
        tdo_d      = tdo_q;
        tms_ones_d = tms_ones_q;
        if (bus.tck && !tck_q) begin
            tdi_d      = bus.tdi;
            tms_ones_d = !bus.tms ? 3'h0
                       : (tms_ones_q == 3'h5) ? 3'h5 : 3'(tms_ones_q + 3'h1);
        end
        if (!bus.tck && tck_q) begin
            tdo_d = tdi_q;
        end
        tdo_oe_d = (tms_ones_d != 3'h5);
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            tck_q      <= 1'b0;
            tdi_q      <= 1'b0;
            tdo_q      <= 1'b0;
            tdo_oe_q   <= 1'b1;
            tms_ones_q <= 3'h0;
        end else if (i_clk_en) begin
            tck_q      <= tck_d;
            tdi_q      <= tdi_d;
            tdo_q      <= tdo_d;
            tdo_oe_q   <= tdo_oe_d;
            tms_ones_q <= tms_ones_d;
        end
    end

    assign bus.tdo    = tdo_q;
    assign bus.tdo_oe = tdo_oe_q;
endmodule : pssa_mem
`default_nettype wire

// ==== hdl/pssa_host.sv ====
// Host end: controller issuing single reads and writes to the SRAM.
`timescale 1ns/10ps
`default_nettype none
module pssa_host
    import pssa_pkg::*;
(
    input  wire logic              i_ref_clk,
    input  wire logic              i_srst,
    input  wire logic              i_clk_en,
    input  wire logic              i_req,
    input  wire logic              i_we,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic [LANES-1:0]  i_be,
    input  wire logic              i_interleave,
    pssa_if.host                   bus,
    output logic                   o_ready,
    output logic                   o_done,
    output logic [DATA_W-1:0]      o_rdata
);
    pssa_host_state_type st_q, st_d;
    logic              we_q, we_d;
    logic [ADDR_W-1:0] a_q, a_d;
    logic [DATA_W-1:0] wd_q, wd_d;
    logic [LANES-1:0]  be_q, be_d;
    logic [1:0]        n_q, n_d;
    logic              rdy_q, rdy_d;
    logic              done_q, done_d;
    logic [DATA_W-1:0] rd_q, rd_d;
    logic [5:0]        jt_q, jt_d;

    always_comb begin
        st_d   = st_q;
        we_d   = we_q;
        a_d    = a_q;
        wd_d   = wd_q;
        be_d   = be_q;
        n_d    = n_q;
        rdy_d  = 1'b0;
        done_d = 1'b0;
        rd_d   = rd_q;
        jt_d   = 6'(jt_q + 6'h1);
        unique case (st_q)
            PSSA_IDLE_ST: begin
                rdy_d = 1'b1;
                if (i_req && rdy_q) begin
                    st_d  = PSSA_ISSUE_ST;
                    we_d  = i_we;
                    a_d   = i_addr;
                    wd_d  = i_wdata;
                    be_d  = i_be;
                    rdy_d = 1'b0;
                end
            end
            PSSA_ISSUE_ST: begin
                st_d = PSSA_WAIT_ST;
                n_d  = 2'h0;
            end
            PSSA_WAIT_ST: begin
                n_d = 2'(n_q + 2'h1);
                if (n_q == 2'(WR_LAT - 1)) begin
                    st_d = PSSA_DONE_ST;
                    if (!we_q) begin
                        rd_d = bus.dq;
                    end
                end
            end
            PSSA_DONE_ST: begin
                st_d   = PSSA_IDLE_ST;
                done_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            st_q   <= PSSA_IDLE_ST;
            we_q   <= 1'b0;
            a_q    <= '0;
            wd_q   <= '0;
            be_q   <= '0;
            n_q    <= 2'h0;
            rdy_q  <= 1'b0;
            done_q <= 1'b0;
            rd_q   <= '0;
            jt_q   <= 6'h0;
        end else if (i_clk_en) begin
            st_q   <= st_d;
            we_q   <= we_d;
            a_q    <= a_d;
            wd_q   <= wd_d;
            be_q   <= be_d;
            n_q    <= n_d;
            rdy_q  <= rdy_d;
            done_q <= done_d;
            rd_q   <= rd_d;
            jt_q   <= jt_d;
        end
    end

    // Outside the issue cycle the memory is deselected with a load, so a fresh address follows.
    assign bus.clock_qualifier_n  = !i_clk_en;
    assign bus.chip_select_1_n    = (st_q != PSSA_ISSUE_ST);
    assign bus.chip_select_2      = (st_q == PSSA_ISSUE_ST);
    assign bus.chip_select_3_n    = (st_q != PSSA_ISSUE_ST);
    assign bus.step_or_load_n     = 1'b0;
    assign bus.write_sel_n        = !we_q;
    assign bus.addr               = a_q;
    assign bus.byte_lane_select_n = ~be_q;
    assign bus.out_enable_n       = we_q;
    assign bus.burst_order        = i_interleave;
    assign bus.dq_host_o          = wd_q;
    // Write data stands in the cycle that ends two qualified edges after the issue.
    assign bus.dq_host_oe         = we_q && (st_q == PSSA_WAIT_ST)
                                    && (n_q == 2'(WR_LAT - 1));
    // Free-running test port pattern: a slow test clock with data and mode select.
    assign bus.tck                = jt_q[1];
    assign bus.tms                = jt_q[5];
    assign bus.tdi                = jt_q[3];
    assign o_ready                = rdy_q;
    assign o_done                 = done_q;
    assign o_rdata                = rd_q;
endmodule : pssa_host
`default_nettype wire

// ==== verification/pssa_assertions.sv ====
// Checker for the SRAM pins between controller and memory.
`timescale 1ns/10ps
`default_nettype none
module pssa_assertions
    import pssa_pkg::*;
(
    input wire logic              i_ref_clk,
    input wire logic              i_srst,
    input wire logic              i_clk_en,
    input wire logic              clock_qualifier_n,
    input wire logic              chip_select_1_n,
    input wire logic              chip_select_2,
    input wire logic              chip_select_3_n,
    input wire logic              step_or_load_n,
    input wire logic              write_sel_n,
    input wire logic              out_enable_n,
    input wire logic [DATA_W-1:0] dq_mem_o,
    input wire logic              dq_mem_oe,
    input wire logic              dq_host_oe,
    input wire logic              tck,
    input wire logic              tms,
    input wire logic              tdi,
    input wire logic              tdo,
    input wire logic              tdo_oe
);
    // ----------------
    // Cycle decode
    // ----------------
    logic q;
    logic sel;
    logic go;
    assign q   = i_clk_en & ~clock_qualifier_n;
    assign sel = ~chip_select_1_n & chip_select_2 & ~chip_select_3_n;
    assign go  = q & sel & ~step_or_load_n;
    // Test clock edges as the memory sees them: one clock late, held while stalled.
    logic tck_q;
    logic tdi_seen_q;
    logic t_rise;
    logic t_fall;
    assign t_rise = i_clk_en & tck & ~tck_q;
    assign t_fall = i_clk_en & ~tck & tck_q;
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            tck_q <= 1'b0;
        end else if (i_clk_en) begin
            tck_q <= tck;
            if (t_rise) begin
                tdi_seen_q <= tdi;
            end
        end
    end
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_srst);
    // ----------------
    // Checks
    // ----------------
    hold_frozen_a: assert property (!q && !i_srst |=> $stable(dq_mem_o))
        else $error("Read register moved on a held edge.");
    read_drive_a: assert property (go && write_sel_n ##1 q |=> out_enable_n || dq_mem_oe)
        else $error("Read data not driven after the next edge.");
    desel_float_a: assert property (q && !sel ##1 q |=> !dq_mem_oe)
        else $error("Outputs still driven after a deselect.");
    write_float_a: assert property (go && !write_sel_n ##1 q |=> !dq_mem_oe)
        else $error("Memory drives during write data.");
    reset_float_a: assert property ($fell(i_srst) |-> !dq_mem_oe)
        else $error("Outputs driven after reset.");
    oe_gate_a: assert property (out_enable_n |-> !dq_mem_oe)
        else $error("Outputs driven with enable high.");
    no_clash_a: assert property (!(dq_mem_oe && dq_host_oe))
        else $error("Both ends drive the data bus.");
    write_data_a: assert property (go && !write_sel_n ##1 q ##1 q |-> dq_host_oe)
        else $error("Write data missing two edges after issue.");
    tdo_shift_a: assert property (t_fall |=> tdo == tdi_seen_q)
        else $error("Test data out is not the bit taken at the last rise.");
    tdo_hold_a: assert property (!t_fall |=> $stable(tdo))
        else $error("Test data out moved without a falling test clock.");
    tap_live_a: assert property (t_rise && !tms |=> tdo_oe)
        else $error("Test output off after a rise with mode select low.");
    rd_seen_c: cover property (go && write_sel_n);
    wr_seen_c: cover property (go && !write_sel_n);
    stall_seen_c: cover property (!i_clk_en ##1 !i_clk_en);
endmodule // pssa_assertions
`default_nettype wire

// ==== verification/pipelined_sync_sram_access_tb.sv ====
// Self-checking bench joining the controller and memory ends.
`timescale 1ns/10ps
`default_nettype none
module pipelined_sync_sram_access_tb
    import pssa_pkg::*;
;
    localparam logic [DATA_W-1:0] PAT = 36'h9a5c3e1f0;
    logic              i_ref_clk;
    logic              i_srst;
    logic              i_clk_en;
    logic              i_req;
    logic              i_we;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wdata;
    logic [LANES-1:0]  i_be;
    logic              i_interleave;
    logic              o_ready;
    logic              o_done;
    logic              o_busy;
    logic [DATA_W-1:0] o_rdata;
    int                mismatches = 0;
    int                cmp_count = 0;

    pssa_if pssa_if_i();
    pssa_mem pssa_mem_i (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_clk_en(i_clk_en),
        .bus(pssa_if_i), .o_busy(o_busy));
    pssa_host pssa_host_i (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_clk_en(i_clk_en),
        .i_req(i_req), .i_we(i_we), .i_addr(i_addr), .i_wdata(i_wdata), .i_be(i_be),
        .i_interleave(i_interleave), .bus(pssa_if_i), .o_ready(o_ready),
        .o_done(o_done), .o_rdata(o_rdata));
    pssa_assertions pssa_assertions_i (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
        .i_clk_en(i_clk_en), .clock_qualifier_n(pssa_if_i.clock_qualifier_n),
        .chip_select_1_n(pssa_if_i.chip_select_1_n), .chip_select_2(pssa_if_i.chip_select_2),
        .chip_select_3_n(pssa_if_i.chip_select_3_n),
        .step_or_load_n(pssa_if_i.step_or_load_n), .write_sel_n(pssa_if_i.write_sel_n),
        .out_enable_n(pssa_if_i.out_enable_n), .dq_mem_o(pssa_if_i.dq_mem_o),
        .dq_mem_oe(pssa_if_i.dq_mem_oe), .dq_host_oe(pssa_if_i.dq_host_oe),
        .tck(pssa_if_i.tck), .tms(pssa_if_i.tms), .tdi(pssa_if_i.tdi),
        .tdo(pssa_if_i.tdo), .tdo_oe(pssa_if_i.tdo_oe));

    // ----------------
    // Shared tasks
    // ----------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // A wait that runs past its bound ends the run as a failure.
    task automatic tick(inout int n);
        @(negedge i_ref_clk);
        n++;
        if (n > 200) begin
            mismatches++;
            give_verdict();
        end
    endtask

    // One host operation; for a read, d is the expected word.
    task automatic op(input logic we, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, input logic [LANES-1:0] be,
                      input int stall);
        int n;
        logic busy_seen;
        n = 0;
        busy_seen = 1'b0;
        while (o_ready !== 1'b1) tick(n);
        i_req = 1'b1;
        i_we = we;
        i_addr = a;
        i_wdata = d;
        i_be = be;
        tick(n);
        i_req = 1'b0;
        chk_pin(pssa_if_i.addr, a);
        chk_pin({7'h0, pssa_if_i.write_sel_n}, {7'h0, ~we});
        chk_pin({7'h0, pssa_if_i.burst_order}, {7'h0, i_interleave});
        if (we) chk_pin({4'h0, pssa_if_i.byte_lane_select_n}, {4'h0, ~be});
        if (stall > 0) begin
            i_clk_en = 1'b0;
            repeat (stall) begin
                tick(n);
                chk_pin({7'h0, o_done}, 8'h0);
            end
            i_clk_en = 1'b1;
        end
        while (o_done !== 1'b1) begin
            if (we && pssa_if_i.dq_host_oe === 1'b1) chk_word(pssa_if_i.dq, d);
            if (o_busy === 1'b1) busy_seen = 1'b1;
            tick(n);
        end
        chk_pin({7'h0, busy_seen}, 8'h1);
        chk_pin({7'h0, o_busy}, 8'h0);
        if (!we) chk_word(o_rdata, d);
    endtask

    // ----------------
    // Scenarios
    // ----------------
    task automatic sc_rw();
        logic [ADDR_W-1:0] a [4] = '{8'h00, 8'h01, 8'h7f, 8'hff};
        for (int i = 0; i < 4; i++) begin
            op(1'b1, a[i], PAT ^ DATA_W'(a[i]), 4'hf, 0);
        end
        for (int i = 0; i < 4; i++) begin
            op(1'b0, a[i], PAT ^ DATA_W'(a[i]), 4'hf, 0);
        end
    endtask

    task automatic sc_lanes();
        logic [DATA_W-1:0] m;
        for (int k = 0; k < LANES; k++) begin
            m = {{(DATA_W-LANE_W){1'b0}}, {LANE_W{1'b1}}} << (LANE_W * k);
            i_interleave = k[0];
            op(1'b1, 8'h40, '1, 4'hf, 0);
            op(1'b1, 8'h40, '0, 4'h1 << k, 0);
            op(1'b0, 8'h40, ~m, 4'hf, 0);
        end
    endtask

    task automatic sc_freeze();
        op(1'b1, 8'h22, PAT, 4'hf, 6);
        op(1'b0, 8'h22, PAT, 4'hf, 0);
    endtask

    // The test output turns off after a run of mode-select rises and back on after a low one.
    task automatic sc_tport();
        int n;
        n = 0;
        while (pssa_if_i.tdo_oe !== 1'b0) tick(n);
        chk_pin({7'h0, pssa_if_i.tms}, 8'h1);
        while (pssa_if_i.tdo_oe !== 1'b1) tick(n);
        chk_pin({7'h0, pssa_if_i.tms}, 8'h0);
    endtask

    initial begin
        i_ref_clk = 1'b0;
        forever #25 i_ref_clk = ~i_ref_clk;
    end

    initial begin
        i_srst = 1'b1;
        i_clk_en = 1'b1;
        i_req = 1'b0;
        i_we = 1'b0;
        i_addr = 8'h0;
        i_wdata = '0;
        i_be = 4'h0;
        i_interleave = 1'b1;
        repeat (6) @(negedge i_ref_clk);
        i_srst = 1'b0;
        @(negedge i_ref_clk);
        chk_pin({7'h0, pssa_if_i.dq_mem_oe}, 8'h0);
        sc_rw();
        sc_lanes();
        sc_freeze();
        sc_tport();
        give_verdict();
    end
endmodule // pipelined_sync_sram_access_tb
`default_nettype wire
